/* design/ecf_pkg.sv */
/*
 * Shared constants and types of the event counter bank: sizes, the register map,
 * the layout of a counter configuration word and the timing-free reset values.
 * Assumes a single core clock and a synchronous active-low reset in every user.
 */
package ecf_pkg;

	// Bank organisation.
	localparam int NUM_CNT = 18;
	localparam int EV_W = 4;
	localparam int THR_W = 4;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 6;
	localparam int IDX_W = 5;
	localparam int BLK_SIZE = 4;
	localparam int LAST_BLK_BASE = 12;
	localparam int CNT_W_DEFAULT = 32;

	// Register map: word index = 2 * counter + 0 for configuration, + 1 for count.
	localparam logic [0:0] SEL_CFG = 1'h0;
	localparam logic [0:0] SEL_CNT = 1'h1;

	// Field positions of a counter configuration word.
	localparam int POS_ENABLE = 0;
	localparam int POS_COMPARE = 1;
	localparam int POS_COMPLEMENT = 2;
	localparam int POS_EDGE = 3;
	localparam int POS_FORCE_OVERFLOW_FLAG = 4;
	localparam int POS_OVF_INT_EN = 5;
	localparam int POS_CASCADE = 6;
	localparam int POS_OVF_FLAG = 7;
	localparam int POS_EXT_CASCADE = 11;
	localparam int POS_THRESHOLD = 12;

	// Reset values.
	localparam logic [DATA_W-1:0] CFG_RESET = 32'h0000_0000;
	localparam logic [DATA_W-1:0] CNT_RESET = 32'h0000_0000;

	// Software-visible configuration of one counter.
	typedef struct packed {
		logic enable;
		logic compare;
		logic complement;
		logic edge_en;
		logic force_overflow_flag;
		logic ovf_int_en;
		logic cascade;
		logic ext_cascade;
		logic [THR_W-1:0] threshold;
	} ecf_cfg_s;

	// One register access from software.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} ecf_bus_s;

endpackage : ecf_pkg

/* design/ecf_counter.sv */
/*
 * One event counter with its threshold comparator and rising-edge filter.
 * Assumes the event lines come from logic on the same clock and that the
 * parent decides when the counter runs and keeps its overflow flag.
 */
module ecf_counter #(
	parameter int CNT_W = ecf_pkg::CNT_W_DEFAULT
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Events and control.
	input wire logic [ecf_pkg::EV_W-1:0] event_i,
	input wire ecf_pkg::ecf_cfg_s cfg_i,
	input wire logic run_i,
	// Software preset of the count.
	input wire logic load_i,
	input wire logic [CNT_W-1:0] load_value_i,
	// State.
	output logic [CNT_W-1:0] count_o,
	output logic ovf_pulse_o
);

	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] count_next;
	logic thr_prev_reg;
	logic above_w;
	logic thr_out_w;
	logic edge_w;
	logic [ecf_pkg::EV_W-1:0] inc_w;
	logic [CNT_W:0] sum_w;
	logic carry_w;

	// Threshold filter, edge filter and increment selection.
	assign above_w = event_i > cfg_i.threshold;
	assign thr_out_w = cfg_i.complement ? ~above_w : above_w;
	assign edge_w = thr_out_w & ~thr_prev_reg;
	assign inc_w = !cfg_i.compare ? event_i :
		((cfg_i.edge_en ? edge_w : thr_out_w) ? 4'h1 : 4'h0);
	// Wrap-around add; the carry marks a pass over the maximum count.
	assign sum_w = {1'b0, count_reg} + {{(CNT_W + 1 - ecf_pkg::EV_W){1'b0}}, inc_w};
	assign carry_w = sum_w[CNT_W];
	assign count_next = load_i ? load_value_i : (run_i ? sum_w[CNT_W-1:0] : count_reg);
	// Forced overflow reports every nonzero increment as an overflow.
	assign ovf_pulse_o = run_i & ~load_i & (carry_w | (cfg_i.force_overflow_flag & (inc_w != 4'h0)));
	assign count_o = count_reg;

	// Count and the last threshold output, sampled every clock.
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			count_reg <= '0;
			thr_prev_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			thr_prev_reg <= thr_out_w;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	AST_RAW_ADD: assert property (run_i && !load_i && !cfg_i.compare |=>
		count_reg == CNT_W'($past(count_reg) + $past(event_i)))
		else $error("Raw event value not added to count.");
	AST_THR_ONE: assert property (run_i && !load_i && cfg_i.compare |=>
		(CNT_W'(count_reg - $past(count_reg)) == CNT_W'($past(thr_out_w))) || $past(cfg_i.edge_en))
		else $error("Threshold hit did not add exactly one.");
	AST_EDGE_HOLD: assert property (run_i && !load_i && cfg_i.compare && cfg_i.edge_en
		&& thr_prev_reg |=> $stable(count_reg))
		else $error("Edge filter counted without a rising edge.");
	AST_HALT: assert property (!run_i && !load_i |=> $stable(count_reg))
		else $error("Halted counter changed.");
	AST_WRAP: assert property (ovf_pulse_o && carry_w |=> count_reg < $past(count_reg))
		else $error("Overflow did not wrap the count.");
	AST_FORCE: assert property (run_i && !load_i && cfg_i.force_overflow_flag && inc_w != 4'h0
		|-> ovf_pulse_o)
		else $error("Forced overflow not reported.");

endmodule : ecf_counter

/* design/ecf_top.sv */
/*
 * Bank of eighteen event counters with software registers, overflow flags,
 * ordinary and extended cascading, and an overflow interrupt request.
 * Assumes event lines and the register port come from logic on clk_i.
 */
// Behaviour
// - Add weighted four-line input each enabled clock.
// - Compare input: complement gives <=, else >.
// - Threshold is four bits, 0 to 15.
// - Satisfied comparison adds one, else zero.
// - Edge flag ignored unless compare set.
// - Edge filter counts only false-to-true transitions.
// - Enable flag starts counting until cleared.
// - Count readable anytime without disturbing counting.
// - Passing maximum wraps to zero, flags overflow.
// - Overflow flag sticky until software clears.
// - Clearing enable halts counter, value held.
// - Cascade set, enable clear: alternate overflow starts.
// - Cascaded stops on cascade or source-flag clear.
// - Eighteen counters, nine pairs, four blocks.
// - Counters 0/2 and 1/3 cascade each block.
// - Counter 16 from 14 only; analogous 17.
// - Counters 16, 17 never start ordinary cascades.
// - Bit 11 extends cascade, last block only.
// - Extended bits: 4->0, 5->3, 5->4, 4->5.
// - Overflow with interrupt enable raises request.
// - Force flag makes every increment an overflow.
module ecf_top #(
	parameter int CNT_W = ecf_pkg::CNT_W_DEFAULT
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Processor event lines, four per counter.
	input wire logic [ecf_pkg::NUM_CNT*ecf_pkg::EV_W-1:0] events_i,
	// Register port.
	input wire logic [ecf_pkg::ADDR_W-1:0] addr_i,
	input wire logic [ecf_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [ecf_pkg::DATA_W-1:0] rdata_o,
	// Status.
	output logic [ecf_pkg::NUM_CNT-1:0] ovf_flags_o,
	output logic pmi_o
);

	localparam int N = ecf_pkg::NUM_CNT;

	// Ordinary cascade source of a counter; valid is always set, as every counter has one.
	function automatic logic [ecf_pkg::IDX_W:0] ord_src(input int idx);
		int rel;
		int base;
		rel = idx % ecf_pkg::BLK_SIZE;
		base = idx - rel;
		if (idx >= ecf_pkg::LAST_BLK_BASE + ecf_pkg::BLK_SIZE) begin
			ord_src = {1'b1, 5'(idx - 2)};
		end else begin
			ord_src = {1'b1, 5'(base + (rel ^ 2))};
		end
	endfunction : ord_src

	// Extended cascade source, only for the last block.
	function automatic logic [ecf_pkg::IDX_W:0] ext_src(input int idx);
		case (idx - ecf_pkg::LAST_BLK_BASE)
			0: ext_src = {1'b1, 5'(ecf_pkg::LAST_BLK_BASE + 4)};
			3: ext_src = {1'b1, 5'(ecf_pkg::LAST_BLK_BASE + 5)};
			4: ext_src = {1'b1, 5'(ecf_pkg::LAST_BLK_BASE + 5)};
			5: ext_src = {1'b1, 5'(ecf_pkg::LAST_BLK_BASE + 4)};
			default: ext_src = 6'h00;
		endcase
	endfunction : ext_src

	// Builds the configuration from a written word.
	function automatic ecf_pkg::ecf_cfg_s word_to_cfg(input logic [31:0] w, input logic ext_ok);
		ecf_pkg::ecf_cfg_s c;
		c.enable = w[ecf_pkg::POS_ENABLE];
		c.compare = w[ecf_pkg::POS_COMPARE];
		c.complement = w[ecf_pkg::POS_COMPLEMENT];
		c.edge_en = w[ecf_pkg::POS_EDGE];
		c.force_overflow_flag = w[ecf_pkg::POS_FORCE_OVERFLOW_FLAG];
		c.ovf_int_en = w[ecf_pkg::POS_OVF_INT_EN];
		c.cascade = w[ecf_pkg::POS_CASCADE];
		c.ext_cascade = w[ecf_pkg::POS_EXT_CASCADE] & ext_ok;
		c.threshold = w[ecf_pkg::POS_THRESHOLD +: ecf_pkg::THR_W];
		return c;
	endfunction : word_to_cfg

	// Lays the configuration and flag out as a read word; other bits are zero.
	function automatic logic [31:0] cfg_to_word(input ecf_pkg::ecf_cfg_s c, input logic ovf);
		logic [31:0] w;
		w = '0;
		w[ecf_pkg::POS_ENABLE] = c.enable;
		w[ecf_pkg::POS_COMPARE] = c.compare;
		w[ecf_pkg::POS_COMPLEMENT] = c.complement;
		w[ecf_pkg::POS_EDGE] = c.edge_en;
		w[ecf_pkg::POS_FORCE_OVERFLOW_FLAG] = c.force_overflow_flag;
		w[ecf_pkg::POS_OVF_INT_EN] = c.ovf_int_en;
		w[ecf_pkg::POS_CASCADE] = c.cascade;
		w[ecf_pkg::POS_OVF_FLAG] = ovf;
		w[ecf_pkg::POS_EXT_CASCADE] = c.ext_cascade;
		w[ecf_pkg::POS_THRESHOLD +: ecf_pkg::THR_W] = c.threshold;
		return w;
	endfunction : cfg_to_word

	ecf_pkg::ecf_cfg_s cfg_reg [N];
	logic [N-1:0] ovf_reg;
	logic [N-1:0] casc_run_reg;
	logic [N-1:0] casc_ext_reg;
	logic [ecf_pkg::DATA_W-1:0] rdata_reg;
	logic [ecf_pkg::DATA_W-1:0] rdata_next;
	logic pmi_reg;
	logic [CNT_W-1:0] count_w [N];
	logic [N-1:0] ovf_pulse_w;
	logic [N-1:0] run_w;
	logic [N-1:0] cfg_wr_w;
	logic [N-1:0] cnt_wr_w;
	logic [N-1:0] pmi_req_w;
	logic [ecf_pkg::IDX_W-1:0] sel_idx_w;
	logic sel_cnt_w;
	logic mapped_w;

	// Address decode: two words per counter, configuration then count.
	assign sel_idx_w = addr_i[ecf_pkg::ADDR_W-1:1];
	assign sel_cnt_w = addr_i[0];
	assign mapped_w = sel_idx_w < ecf_pkg::IDX_W'(N);

	// Read mux; an unmapped address reads zero.
	assign rdata_next = !mapped_w ? '0 :
		(sel_cnt_w == ecf_pkg::SEL_CNT) ? ecf_pkg::DATA_W'(count_w[sel_idx_w]) :
		cfg_to_word(cfg_reg[sel_idx_w], ovf_reg[sel_idx_w]);

	// Read data register and interrupt request.
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rdata_reg <= ecf_pkg::CFG_RESET;
			pmi_reg <= 1'b0;
		end else begin
			rdata_reg <= rd_i ? rdata_next : '0;
			pmi_reg <= |pmi_req_w;
		end
	end

	assign rdata_o = rdata_reg;
	assign ovf_flags_o = ovf_reg;
	assign pmi_o = pmi_reg;

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_cnt
			localparam logic [ecf_pkg::IDX_W:0] ORD = ord_src(i);
			localparam logic [ecf_pkg::IDX_W:0] EXT = ext_src(i);
			logic start_ord_w;
			logic start_ext_w;
			logic stop_w;
			logic ovf_next;

			assign cfg_wr_w[i] = wr_i && mapped_w && sel_idx_w == 5'(i) && sel_cnt_w == ecf_pkg::SEL_CFG;
			assign cnt_wr_w[i] = wr_i && mapped_w && sel_idx_w == 5'(i) && sel_cnt_w == ecf_pkg::SEL_CNT;

			// Cascade start from the alternate counter, or the extended source.
			assign start_ord_w = ORD[ecf_pkg::IDX_W] && cfg_reg[i].cascade && !cfg_reg[i].enable
				&& ovf_pulse_w[ORD[ecf_pkg::IDX_W-1:0]];
			assign start_ext_w = EXT[ecf_pkg::IDX_W] && cfg_reg[i].ext_cascade && !cfg_reg[i].enable
				&& ovf_pulse_w[EXT[ecf_pkg::IDX_W-1:0]];
			// A cascaded run ends when its own flag or the source's overflow flag drops.
			assign stop_w = casc_ext_reg[i] ?
				(!cfg_reg[i].ext_cascade || !ovf_reg[EXT[ecf_pkg::IDX_W-1:0]]) :
				(!cfg_reg[i].cascade || !ovf_reg[ORD[ecf_pkg::IDX_W-1:0]]);
			assign run_w[i] = cfg_reg[i].enable | casc_run_reg[i];
			// Hardware setting the flag wins over a software clear in the same cycle.
			assign ovf_next = ovf_pulse_w[i] |
				(cfg_wr_w[i] ? wdata_i[ecf_pkg::POS_OVF_FLAG] : ovf_reg[i]);
			assign pmi_req_w[i] = ovf_pulse_w[i] & cfg_reg[i].ovf_int_en;

			// Configuration, sticky overflow flag and cascade run state.
			always_ff @(posedge clk_i) begin
				if (!reset_n_i) begin
					cfg_reg[i] <= word_to_cfg(ecf_pkg::CFG_RESET, 1'b0);
					ovf_reg[i] <= 1'b0;
					casc_run_reg[i] <= 1'b0;
					casc_ext_reg[i] <= 1'b0;
				end else begin
					if (cfg_wr_w[i]) begin
						cfg_reg[i] <= word_to_cfg(wdata_i, EXT[ecf_pkg::IDX_W]);
					end
					ovf_reg[i] <= ovf_next;
					if (start_ord_w || start_ext_w) begin
						casc_run_reg[i] <= 1'b1;
						casc_ext_reg[i] <= !start_ord_w;
					end else if (casc_run_reg[i] && stop_w) begin
						casc_run_reg[i] <= 1'b0;
					end
				end
			end

			ecf_counter #(
				.CNT_W(CNT_W)
			) u_counter (
				.clk_i(clk_i),
				.reset_n_i(reset_n_i),
				.event_i(events_i[i*ecf_pkg::EV_W +: ecf_pkg::EV_W]),
				.cfg_i(cfg_reg[i]),
				.run_i(run_w[i]),
				.load_i(cnt_wr_w[i]),
				.load_value_i(CNT_W'(wdata_i)),
				.count_o(count_w[i]),
				.ovf_pulse_o(ovf_pulse_w[i])
			);
		end
	endgenerate

	AST_STICKY: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		##1 (($past(ovf_reg) & ~$past(cfg_wr_w) & ~ovf_reg) == '0))
		else $error("Overflow flag dropped without software clear.");
	AST_SET_WINS: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		ovf_pulse_w[0] |=> ovf_reg[0])
		else $error("Overflow event lost.");
	AST_CASC_START: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		cfg_reg[2].cascade && !cfg_reg[2].enable && ovf_pulse_w[0] |=> run_w[2])
		else $error("Cascade did not start the alternate counter.");
	AST_CASC_STOP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		casc_run_reg[2] && !casc_ext_reg[2] && !ovf_reg[0] && !ovf_pulse_w[0] |=> !casc_run_reg[2])
		else $error("Cascaded counter kept running after source flag clear.");
	AST_NO_12_FROM_16: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!casc_run_reg[12] && !cfg_reg[12].ext_cascade && !ovf_pulse_w[14] |=> !casc_run_reg[12])
		else $error("Counter 12 started by an illegal source.");
	AST_PMI: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		ovf_pulse_w[0] && cfg_reg[0].ovf_int_en |=> pmi_o)
		else $error("Overflow interrupt request missing.");
	AST_READ_ZERO: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!rd_i |=> rdata_o == '0)
		else $error("Read data outside read cycle.");

endmodule : ecf_top

/* testbench/ecf_event_src.sv */
/*
 * Model of the processor event lines that feed the counter bank.
 * Assumes the bench requests bursts synchronously to clk_i.
 */
module ecf_event_src (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Burst request.
	input wire logic go_i,
	input wire logic alt_i,
	input wire logic [17:0] mask_i,
	input wire logic [3:0] val_i,
	input wire logic [7:0] len_i,
	// Event lines and status.
	output logic [71:0] events_o,
	output logic busy_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] left_reg;
	logic phase_reg;
	logic alt_reg;
	logic [17:0] mask_reg;
	logic [3:0] val_reg;

	// Counts down the requested cycles, toggling the value in alternate mode.
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			left_reg <= 8'h00;
			phase_reg <= 1'b0;
			mask_reg <= 18'h00000;
		end else if (go_i) begin
			left_reg <= len_i;
			mask_reg <= mask_i;
			val_reg <= val_i;
			alt_reg <= alt_i;
			phase_reg <= 1'b1;
		end else if (left_reg != 8'h00) begin
			left_reg <= left_reg - 8'h01;
			phase_reg <= alt_reg ? ~phase_reg : 1'b1;
		end
	end

	// Chosen counters see the value while a burst runs, on every other cycle only in alternate mode; all other lines stay quiet.
	always_comb begin
		for (int k = 0; k < 18; k++) begin
			events_o[4*k +: 4] = (busy_o && phase_reg && mask_reg[k]) ? val_reg : 4'h0;
		end
	end
	assign busy_o = left_reg != 8'h00;
endmodule : ecf_event_src

/* testbench/ecf_top_tb.sv */
/*
 * Self-checking bench of the event counter bank with a narrow counter.
 * Assumes the event source model drives the event lines.
 */
module ecf_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int CW = 8;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [5:0] addr_i = 6'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic go = 1'b0;
	logic alt = 1'b0;
	logic [17:0] mask = 18'h0;
	logic [3:0] val = 4'h0;
	logic [7:0] len = 8'h0;
	logic [71:0] events;
	logic busy;
	logic [31:0] rdata_o;
	logic [17:0] ovf_flags_o;
	logic pmi_o;
	logic rd_d = 1'b0;
	logic [31:0] exp_q[$];
	logic [31:0] seed = 32'h35;
	logic [3:0] v4;
	logic [3:0] th;
	logic c;
	int miscompares = 0;
	int compares = 0;
	int pmis = 0;
	int i;
	int k;
	int n;
	int p0;

	ecf_top #(.CNT_W(CW)) i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .events_i(events),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.ovf_flags_o(ovf_flags_o), .pmi_o(pmi_o));
	ecf_event_src i_src (.clk_i(clk_i), .reset_n_i(reset_n_i), .go_i(go), .alt_i(alt),
		.mask_i(mask), .val_i(val), .len_i(len), .events_o(events), .busy_o(busy));

	// Free-running core clock.
	always #10 clk_i = ~clk_i;

	// Pseudo-random source for event values and thresholds.
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	task check(input logic [31:0] seen, input logic [31:0] expd);
		compares++;
		if (seen !== expd) begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, expd);
		end
	endtask : check

	task wr(input logic [5:0] a, input logic [31:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		rd_i <= 1'b0;
		@(posedge clk_i);
	endtask : wr

	task rd(input logic [5:0] a, input logic [31:0] expd);
		exp_q.push_back(expd);
		addr_i <= a;
		rd_i <= 1'b1;
		wr_i <= 1'b0;
		@(posedge clk_i);
	endtask : rd

	task idle(input int cyc);
		wr_i <= 1'b0;
		rd_i <= 1'b0;
		repeat (cyc) @(posedge clk_i);
	endtask : idle

	// Asks the source for one burst and waits, bounded, until it is over.
	task pulse(input logic [17:0] m, input logic [3:0] v, input logic [7:0] nn, input logic a);
		int w;
		idle(2);
		mask <= m;
		val <= v;
		len <= nn;
		alt <= a;
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		w = 0;
		do begin
			@(posedge clk_i);
			#1;
			w++;
		end while (busy === 1'b1 && w < 300);
		@(posedge clk_i);
		idle(2);
	endtask : pulse

	task results;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results

	// Read data stand in the cycle after the strobe; compare them with the oldest note.
	always @(posedge clk_i) begin
		if (rd_d) begin
			check(rdata_o, exp_q.pop_front());
		end
		rd_d <= rd_i;
		if (pmi_o === 1'b1) begin
			pmis++;
		end
	end

	// Cuts a hung run short.
	initial begin
		#(20 * 20000);
		miscompares++;
		results();
	end

	// Main sequence of tests.
	initial begin
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		rd(6'h00, 32'h0);
		rd(6'h23, 32'h0);
		wr(6'h00, 32'h0000_f07e);
		rd(6'h00, 32'h0000_f07e);
		wr(6'h1a, 32'h800);
		rd(6'h1a, 32'h0);
		wr(6'h18, 32'h800);
		rd(6'h18, 32'h800);
		wr(6'h28, 32'h1);
		rd(6'h28, 32'h0);
		wr(6'h00, 32'h0);
		idle(1);
		$display("test registers done");
		for (i = 0; i < 6; i++) begin
			seed = xs(seed);
			k = int'(seed[31:16]) % 18;
			v4 = seed[3:0];
			n = int'(seed[7:4]) + 1;
			wr(6'(2 * k), 32'h1);
			wr(6'(2 * k + 1), 32'h0);
			pulse(18'h1 << k, v4, 8'(n), 1'b0);
			rd(6'(2 * k + 1), 32'(v4 * n));
			wr(6'(2 * k), 32'h0);
			pulse(18'h1 << k, 4'hf, 8'h03, 1'b0);
			rd(6'(2 * k + 1), 32'(v4 * n));
		end
		$display("test raw counting done");
		for (i = 0; i < 8; i++) begin
			seed = xs(seed);
			th = seed[11:8];
			v4 = i[0] ? seed[3:0] : th;
			c = seed[12];
			wr(6'h00, {16'h0, th, 12'h003} | {29'h0, c, 2'h0});
			wr(6'h01, 32'h0);
			pulse(18'h1, v4, 8'h05, 1'b0);
			// With complement set, the six quiet cycles (value 0) also pass the test.
			rd(6'h01, (c ? 32'h6 : 32'h0) + ((c ? v4 <= th : v4 > th) ? 32'h5 : 32'h0));
		end
		wr(6'h00, 32'h0000_000b);
		wr(6'h01, 32'h0);
		pulse(18'h1, 4'h5, 8'h08, 1'b1);
		rd(6'h01, 32'h4);
		wr(6'h00, 32'h0000_0009);
		wr(6'h01, 32'h0);
		pulse(18'h1, 4'h5, 8'h08, 1'b1);
		rd(6'h01, 32'h14);
		$display("test filters done");
		wr(6'h00, 32'h1);
		wr(6'h01, 32'hfd);
		pulse(18'h1, 4'h2, 8'h02, 1'b0);
		rd(6'h01, 32'h1);
		pulse(18'h1, 4'h3, 8'h01, 1'b0);
		rd(6'h01, 32'h4);
		rd(6'h00, 32'h81);
		wr(6'h00, 32'h1);
		rd(6'h00, 32'h1);
		wr(6'h00, 32'h31);
		wr(6'h01, 32'h0);
		p0 = pmis;
		pulse(18'h1, 4'h1, 8'h03, 1'b0);
		idle(2);
		check(32'(pmis - p0), 32'h3);
		rd(6'h00, 32'hb1);
		$display("test overflow done");
		wr(6'h00, 32'h1);
		wr(6'h01, 32'hff);
		wr(6'h04, 32'h40);
		wr(6'h05, 32'h0);
		pulse(18'h1, 4'h1, 8'h01, 1'b0);
		pulse(18'h4, 4'h3, 8'h04, 1'b0);
		rd(6'h05, 32'hc);
		wr(6'h00, 32'h1);
		pulse(18'h4, 4'h3, 8'h04, 1'b0);
		rd(6'h05, 32'hc);
		// The random raw loop may have touched these counters, so set them up again.
		wr(6'h18, 32'h800);
		wr(6'h1d, 32'h0);
		wr(6'h20, 32'h1);
		wr(6'h21, 32'hff);
		wr(6'h1c, 32'h40);
		wr(6'h19, 32'h0);
		pulse(18'h10000, 4'h1, 8'h01, 1'b0);
		pulse(18'h05000, 4'h2, 8'h03, 1'b0);
		rd(6'h19, 32'h6);
		rd(6'h1d, 32'h0);
		idle(3);
		$display("test cascading done");
		results();
	end
endmodule : ecf_top_tb
